// *** core/imu_ctrl.sv ***
// operational control register bank of the inertial sensor
`include "imu_defs.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - restore clears calibration, data, ends within 50 ms
// - misc bit 7 bias compensation, bit 6 percussion
// - command bits start on 1, self-clear on completion
// - bit 7 halts, restarts, reloads control registers
// - read of command register starts burst read
// - command bits 4,3,2,1,0 map to their operations
// - period is time base times increment plus one
// - sample period resets to 0x0001
// - sample period 0x0A or more means low power
// - bit 8 sleeps until chip-select falls
// - bits 7:0 sleep count times half second
// - two averaging stages, tap exponent at most 6
// - range bits 10:8 select 300, 150, 75 deg/s
// - low ranges raise tap setting to floor
// - line owner: misc, then alarm, then pins
// - direction bits 3:0, levels bits 11:8
// - sample period low byte zero selects external clock
// - data-ready pulse active high on line 1
// - misc bits 2:0 enable, polarity, line select
// - misc bits 11,10 start tests, clear when done
// - misc bits 9,8 apply self-test stimulus
////////////////////////////////////////////////////////////////////////////

module imu_ctrl #(
  parameter int TB0_CYC    = int'($floor(`IMU_TB0_MS * `IMU_CLK_MHZ * 1000.0)),
  parameter int TB1_CYC    = int'($floor(`IMU_TB1_MS * `IMU_CLK_MHZ * 1000.0)),
  parameter int DRDY_CYC   = (`IMU_DRDY_MIN_US + `IMU_DRDY_MAX_US) / 2
                             * `IMU_CLK_MHZ,
  parameter int NV_CYC     = `IMU_NV_MS * `IMU_CLK_MHZ * 1000,
  parameter int HALF_S_CYC = `IMU_SLEEP_LSB_MS * `IMU_CLK_MHZ * 1000
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             spi_sclk,
  input  wire logic             spi_cs_n,
  input  wire logic             spi_mosi,
  output logic                  spi_miso,
  output logic                  spi_miso_oe_n,
  input  wire logic             ext_sample_clk,
  input  wire logic [3:0]       dio_in,
  output logic      [3:0]       dio_out,
  output logic      [3:0]       dio_oe_n,
  input  wire logic [3:0]       alarm_own,
  input  wire logic [3:0]       alarm_lvl,
  input  wire logic [7:0]       op_done,
  input  wire logic [1:0]       test_done,
  output logic      [7:0]       op_start,
  output logic      [1:0]       test_start,
  output logic                  burst_start,
  output logic                  sample_tick,
  output logic                  startup_busy,
  output logic                  sleeping,
  output imu_pkg::imu_cfg_t     cfg
);

  logic [7:0]        sync_a;
  logic [7:0]        sync_b;
  logic [7:0]        sync_c;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              cs_act;
  logic              cs_fall;
  logic              mosi_s;
  logic              ext_rise;
  logic [3:0]        dio_s;
  logic [3:0]        bit_cnt;
  logic [15:0]       rx_sh;
  logic [15:0]       tx_sh;
  logic [15:0]       word;
  logic [6:0]        rd_addr;
  logic              word_done;
  logic              rd_cmd;
  logic              wr_en;
  logic [6:0]        wr_a;
  logic [7:0]        wr_d;
  logic [15:0]       gcmd;
  logic [15:0]       misc;
  logic [15:0]       smpl;
  logic [15:0]       sens;
  logic [15:0]       iol;
  logic [15:0]       slp;
  logic [15:0]       next_gcmd;
  logic [15:0]       next_misc;
  logic [15:0]       next_smpl;
  logic [15:0]       next_sens;
  logic [15:0]       next_iol;
  logic [15:0]       next_slp;
  logic [15:0]       g_set;
  logic [3:0]        io_lvl_rd;
  logic              reload;
  logic              srst_done;
  logic              nv_to;
  logic [31:0]       nv_cnt;
  logic [31:0]       st_cnt;
  imu_pkg::imu_run_t run;
  imu_pkg::imu_pwr_t pwr;
  logic [7:0]        slp_rem;
  logic [31:0]       half_cnt;
  logic              slp_lo_wr;
  logic              slp_ind_wr;
  logic              wake;
  logic              run_ok;
  logic              ext_mode;
  logic [31:0]       tb_lim;
  logic [31:0]       tb_cnt;
  logic [6:0]        inc_cnt;
  logic [31:0]       dr_cnt;
  logic              dr_act;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] b);
    return a[6:1] == b[6:1];
  endfunction : hit

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [6:0]  a,
                                        input logic [6:0]  base,
                                        input logic [7:0]  d,
                                        input logic [15:0] msk);
    logic [15:0] v;
    v = old;
    if (a == base) begin
      v[7:0] = d;
    end else if (a == (base | `IMU_HI_BYTE)) begin
      v[15:8] = d;
    end
    return v & msk;
  endfunction : merge

  function automatic logic [15:0] sens_fix(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    if (r[`IMU_SENS_TAP] > `IMU_TAP_MAX) begin
      r[`IMU_SENS_TAP] = `IMU_TAP_MAX;
    end
    if (r[`IMU_SENS_RNG] == `IMU_RNG_150 &&
        r[`IMU_SENS_TAP] < `IMU_TAP_MIN150) begin
      r[`IMU_SENS_TAP] = `IMU_TAP_MIN150;
    end
    if (r[`IMU_SENS_RNG] == `IMU_RNG_75 &&
        r[`IMU_SENS_TAP] < `IMU_TAP_MIN75) begin
      r[`IMU_SENS_TAP] = `IMU_TAP_MIN75;
    end
    return r;
  endfunction : sens_fix

  function automatic logic [15:0] rd_word(input logic [6:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (hit(a, `IMU_ADR_GCMD)) begin
      v = gcmd;
    end else if (hit(a, `IMU_ADR_MISC)) begin
      v = misc;
    end else if (hit(a, `IMU_ADR_SMPL)) begin
      v = smpl;
    end else if (hit(a, `IMU_ADR_SENS)) begin
      v = sens;
    end else if (hit(a, `IMU_ADR_SLP)) begin
      v = slp;
    end else if (hit(a, `IMU_ADR_IOL)) begin
      v = {4'h0, io_lvl_rd, 4'h0, iol[`IMU_IOL_DIR]};
    end
    return v;
  endfunction : rd_word

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_a <= 8'hC0;
      sync_b <= 8'hC0;
      sync_c <= 8'hC0;
    end else begin
      sync_a <= {spi_sclk, spi_cs_n, spi_mosi, ext_sample_clk, dio_in};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign sclk_rise = sync_b[7] & ~sync_c[7];
  assign sclk_fall = ~sync_b[7] & sync_c[7];
  assign cs_act    = ~sync_b[6];
  assign cs_fall   = ~sync_b[6] & sync_c[6];
  assign mosi_s    = sync_b[5];
  assign ext_rise  = sync_b[4] & ~sync_c[4];
  assign dio_s     = sync_b[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // serial port
  assign word      = {rx_sh[14:0], mosi_s};
  assign word_done = cs_act & sclk_rise & (bit_cnt == 4'hF);
  assign rd_cmd    = word_done & ~word[`IMU_WR_BIT];
  assign wr_en     = word_done & word[`IMU_WR_BIT];
  assign wr_a      = word[14:8];
  assign wr_d      = word[7:0];
  assign spi_miso  = tx_sh[15];
  assign io_lvl_rd = (iol[`IMU_IOL_LVL] & iol[`IMU_IOL_DIR]) |
                     (dio_s & ~iol[`IMU_IOL_DIR]);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bit_cnt <= 4'h0;
      rx_sh   <= 16'h0000;
      tx_sh   <= 16'h0000;
      rd_addr <= 7'h00;
    end else if (cs_fall) begin
      bit_cnt <= 4'h0;
      tx_sh   <= rd_word(rd_addr);
    end else if (cs_act && sclk_rise) begin
      rx_sh   <= word;
      bit_cnt <= bit_cnt + 4'h1;
      if (rd_cmd) begin
        rd_addr <= wr_a;
        tx_sh   <= rd_word(wr_a);
      end else if (word_done) begin
        tx_sh   <= rd_word(rd_addr);
      end
    end else if (cs_act && sclk_fall && bit_cnt != 4'h0) begin
      tx_sh <= {tx_sh[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      spi_miso_oe_n <= 1'b1;
      burst_start   <= 1'b0;
    end else begin
      spi_miso_oe_n <= ~cs_act;
      burst_start   <= rd_cmd && hit(wr_a, `IMU_ADR_GCMD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // global commands
  assign g_set  = wr_en ? merge(16'h0000, wr_a, `IMU_ADR_GCMD, wr_d,
                                `IMU_MSK_GCMD) : 16'h0000;
  assign reload = g_set[`IMU_GC_SRST];
  assign nv_to  = gcmd[`IMU_GC_RESTORE] && nv_cnt == 32'(NV_CYC - 1);
  assign srst_done = run == imu_pkg::RUN_STARTUP && st_cnt == 32'h0;

  always_comb begin
    next_gcmd = gcmd & {8'h00, ~op_done};
    next_gcmd[`IMU_GC_SRST] = gcmd[`IMU_GC_SRST] & ~srst_done;
    if (nv_to) begin
      next_gcmd[`IMU_GC_RESTORE] = 1'b0;
    end
    next_gcmd = next_gcmd | g_set;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gcmd     <= `IMU_RST_GCMD;
      op_start <= 8'h00;
      nv_cnt   <= 32'h0;
    end else begin
      gcmd     <= next_gcmd;
      op_start <= g_set[7:0];
      nv_cnt   <= gcmd[`IMU_GC_RESTORE] ? nv_cnt + 32'h1 : 32'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run    <= imu_pkg::RUN_ACTIVE;
      st_cnt <= 32'h0;
    end else begin
      case (run)
        imu_pkg::RUN_ACTIVE: begin
          if (reload) begin
            run    <= imu_pkg::RUN_STARTUP;
            st_cnt <= 32'(`IMU_STARTUP_CYC - 1);
          end
        end
        imu_pkg::RUN_STARTUP: begin
          if (st_cnt == 32'h0) begin
            run <= imu_pkg::RUN_ACTIVE;
          end else begin
            st_cnt <= st_cnt - 32'h1;
          end
        end
        default: run <= imu_pkg::RUN_ACTIVE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_comb begin
    next_misc = misc;
    next_misc[`IMU_MC_MEMTEST] = misc[`IMU_MC_MEMTEST] & ~test_done[1];
    next_misc[`IMU_MC_SELFTST] = misc[`IMU_MC_SELFTST] & ~test_done[0];
    if (wr_en) begin
      next_misc = merge(next_misc, wr_a, `IMU_ADR_MISC, wr_d,
                        `IMU_MSK_MISC);
    end
    next_smpl = wr_en ? merge(smpl, wr_a, `IMU_ADR_SMPL, wr_d,
                              `IMU_MSK_SMPL) : smpl;
    next_sens = sens_fix(wr_en ? merge(sens, wr_a, `IMU_ADR_SENS, wr_d,
                                       `IMU_MSK_SENS) : sens);
    next_iol  = wr_en ? merge(iol, wr_a, `IMU_ADR_IOL, wr_d,
                              `IMU_MSK_IOL) : iol;
    next_slp  = slp;
    if (wake) begin
      next_slp[`IMU_SL_IND] = 1'b0;
    end
    if (wr_en) begin
      next_slp = merge(next_slp, wr_a, `IMU_ADR_SLP, wr_d, `IMU_MSK_SLP);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      misc <= `IMU_RST_MISC;
      smpl <= `IMU_RST_SMPL;
      sens <= `IMU_RST_SENS;
      iol  <= `IMU_RST_IOL;
      slp  <= `IMU_RST_SLP;
    end else if (reload) begin
      misc <= `IMU_RST_MISC;
      smpl <= `IMU_RST_SMPL;
      sens <= `IMU_RST_SENS;
      iol  <= `IMU_RST_IOL;
      slp  <= `IMU_RST_SLP;
    end else begin
      misc <= next_misc;
      smpl <= next_smpl;
      sens <= next_sens;
      iol  <= next_iol;
      slp  <= next_slp;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      test_start <= 2'h0;
    end else if (wr_en && wr_a == (`IMU_ADR_MISC | `IMU_HI_BYTE)) begin
      test_start <= {wr_d[`IMU_MC_MEMTEST - 8],
                     wr_d[`IMU_MC_SELFTST - 8]};
    end else begin
      test_start <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep control
  assign slp_lo_wr  = wr_en && wr_a == `IMU_ADR_SLP && wr_d != 8'h00;
  assign slp_ind_wr = wr_en && wr_a == (`IMU_ADR_SLP | `IMU_HI_BYTE) &&
                      wr_d[`IMU_SL_IND - 8];
  assign wake       = pwr == imu_pkg::PWR_INDEF && cs_fall;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr      <= imu_pkg::PWR_AWAKE;
      slp_rem  <= 8'h00;
      half_cnt <= 32'h0;
    end else if (reload) begin
      pwr <= imu_pkg::PWR_AWAKE;
    end else begin
      case (pwr)
        imu_pkg::PWR_AWAKE: begin
          if (slp_ind_wr) begin
            pwr <= imu_pkg::PWR_INDEF;
          end else if (slp_lo_wr) begin
            pwr      <= imu_pkg::PWR_TIMED;
            slp_rem  <= wr_d;
            half_cnt <= 32'h0;
          end
        end
        imu_pkg::PWR_TIMED: begin
          if (half_cnt == 32'(HALF_S_CYC - 1)) begin
            half_cnt <= 32'h0;
            slp_rem  <= slp_rem - 8'h01;
            if (slp_rem == 8'h01) begin
              pwr <= imu_pkg::PWR_AWAKE;
            end
          end else begin
            half_cnt <= half_cnt + 32'h1;
          end
        end
        imu_pkg::PWR_INDEF: begin
          if (wake) begin
            pwr <= imu_pkg::PWR_AWAKE;
          end
        end
        default: pwr <= imu_pkg::PWR_AWAKE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample timer and data ready
  assign run_ok   = run == imu_pkg::RUN_ACTIVE && pwr == imu_pkg::PWR_AWAKE;
  assign ext_mode = smpl[7:0] == `IMU_EXT_CLK;
  assign tb_lim   = smpl[`IMU_SP_TB] ? 32'(TB1_CYC - 1) : 32'(TB0_CYC - 1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tb_cnt      <= 32'h0;
      inc_cnt     <= 7'h00;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (!run_ok) begin
        tb_cnt  <= 32'h0;
        inc_cnt <= 7'h00;
      end else if (ext_mode) begin
        sample_tick <= ext_rise;
      end else if (tb_cnt >= tb_lim) begin
        tb_cnt <= 32'h0;
        if (inc_cnt >= smpl[`IMU_SP_INC]) begin
          inc_cnt     <= 7'h00;
          sample_tick <= 1'b1;
        end else begin
          inc_cnt <= inc_cnt + 7'h01;
        end
      end else begin
        tb_cnt <= tb_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dr_cnt <= 32'h0;
      dr_act <= 1'b0;
    end else if (sample_tick && misc[`IMU_MC_DREN]) begin
      dr_cnt <= 32'(DRDY_CYC - 1);
      dr_act <= 1'b1;
    end else if (dr_cnt != 32'h0) begin
      dr_cnt <= dr_cnt - 32'h1;
    end else begin
      dr_act <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // io line ownership
  for (genvar i = 0; i < 4; i++) begin : g_dio
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        dio_out[i]  <= 1'b0;
        dio_oe_n[i] <= 1'b1;
      end else if (misc[`IMU_MC_DREN] &&
                   i == (misc[`IMU_MC_DRSEL] ? 1 : 0)) begin
        dio_out[i]  <= misc[`IMU_MC_DRPOL] ? dr_act : ~dr_act;
        dio_oe_n[i] <= 1'b0;
      end else if (alarm_own[i]) begin
        dio_out[i]  <= alarm_lvl[i];
        dio_oe_n[i] <= 1'b0;
      end else begin
        dio_out[i]  <= iol[8 + i];
        dio_oe_n[i] <= ~iol[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg          <= '0;
      startup_busy <= 1'b0;
      sleeping     <= 1'b0;
    end else begin
      cfg.comp_en      <= misc[`IMU_MC_COMP];
      cfg.pop_en       <= misc[`IMU_MC_POP];
      cfg.stim_neg     <= misc[`IMU_MC_STNEG];
      cfg.stim_pos     <= misc[`IMU_MC_STPOS];
      cfg.gyro_range   <= sens[`IMU_SENS_RNG];
      cfg.taps_m       <= sens[`IMU_SENS_TAP];
      cfg.low_power    <= smpl[7:0] >= `IMU_LOWPWR_MIN;
      cfg.ext_clk_mode <= ext_mode;
      startup_busy     <= run == imu_pkg::RUN_STARTUP;
      sleeping         <= pwr != imu_pkg::PWR_AWAKE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic [31:0] hi_len;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hi_len <= 32'h0;
    end else begin
      hi_len <= dr_act ? hi_len + 32'h1 : 32'h0;
    end
  end

  sequence s_srst_write;
    wr_en && wr_a == `IMU_ADR_GCMD && wr_d[`IMU_GC_SRST];
  endsequence
  sequence s_reloaded;
    smpl == `IMU_RST_SMPL && misc == `IMU_RST_MISC &&
    run == imu_pkg::RUN_STARTUP;
  endsequence

  chk_trig_start: assert property (wr_en && wr_a == `IMU_ADR_GCMD && wr_d[0]
    |=> op_start[0] && gcmd[0]) else $error("trigger not started");
  chk_srst_reload: assert property (s_srst_write |=> s_reloaded ##2
    startup_busy) else $error("soft reset did not reload");
  chk_restore_limit: assert property (nv_to && !g_set[`IMU_GC_RESTORE]
    |=> !gcmd[`IMU_GC_RESTORE]) else $error("restore overran");
  chk_burst_start: assert property (rd_cmd && wr_a == `IMU_ADR_GCMD
    |=> burst_start) else $error("burst not started");
  chk_low_power: assert property (cfg.low_power ==
    ($past(smpl[7:0]) >= `IMU_LOWPWR_MIN)) else $error("low power");
  chk_indef_wake: assert property (pwr == imu_pkg::PWR_INDEF && cs_fall
    && !reload |=> pwr == imu_pkg::PWR_AWAKE ##2 !sleeping)
    else $error("no wake on select");
  chk_tap_floor: assert property ((sens[`IMU_SENS_RNG] != `IMU_RNG_75 ||
    sens[`IMU_SENS_TAP] >= `IMU_TAP_MIN75) && (sens[`IMU_SENS_RNG] !=
    `IMU_RNG_150 || sens[`IMU_SENS_TAP] >= `IMU_TAP_MIN150) &&
    sens[`IMU_SENS_TAP] <= `IMU_TAP_MAX) else $error("taps");
  chk_drdy_width: assert property ($fell(dr_act) |->
    hi_len == 32'(DRDY_CYC)) else $error("pulse width");
  chk_ext_clock: assert property (run_ok && ext_mode && ext_rise |=>
    sample_tick) else $error("external tick lost");
  chk_test_clear: assert property (misc[`IMU_MC_SELFTST] && test_done[0]
    && !wr_en && !reload |=> !misc[`IMU_MC_SELFTST])
    else $error("self-test bit stuck");
  chk_unused_zero: assert property ((gcmd & ~`IMU_MSK_GCMD) == 16'h0000 &&
    (misc & ~`IMU_MSK_MISC) == 16'h0000) else $error("unused set");
  chk_drdy_owner: assert property (misc[`IMU_MC_DREN] &&
    !misc[`IMU_MC_DRSEL] && !reload |=> !dio_oe_n[0])
    else $error("line 1 not driven");

endmodule : imu_ctrl

`default_nettype wire

// *** core/imu_defs.svh ***
// register map, field positions, reset values and timing of imu control
`ifndef IMU_DEFS_SVH
`define IMU_DEFS_SVH

`define IMU_ADR_IOL       7'h32
`define IMU_ADR_MISC      7'h34
`define IMU_ADR_SMPL      7'h36
`define IMU_ADR_SENS      7'h38
`define IMU_ADR_SLP       7'h3A
`define IMU_ADR_GCMD      7'h3E
`define IMU_HI_BYTE       7'h01

`define IMU_RST_GCMD      16'h0000
`define IMU_RST_MISC      16'h0006
`define IMU_RST_SMPL      16'h0001
`define IMU_RST_SENS      16'h0400
`define IMU_RST_IOL       16'h0000
`define IMU_RST_SLP       16'h0000

`define IMU_MSK_GCMD      16'h009F
`define IMU_MSK_MISC      16'h0FC7
`define IMU_MSK_SMPL      16'h00FF
`define IMU_MSK_SENS      16'h0707
`define IMU_MSK_IOL       16'h0F0F
`define IMU_MSK_SLP       16'h01FF

`define IMU_GC_SRST       7
`define IMU_GC_RESTORE    1
`define IMU_MC_MEMTEST    11
`define IMU_MC_SELFTST    10
`define IMU_MC_STNEG      9
`define IMU_MC_STPOS      8
`define IMU_MC_COMP       7
`define IMU_MC_POP        6
`define IMU_MC_DREN       2
`define IMU_MC_DRPOL      1
`define IMU_MC_DRSEL      0
`define IMU_SP_TB         7
`define IMU_SP_INC        6:0
`define IMU_SL_IND        8
`define IMU_SENS_RNG      10:8
`define IMU_SENS_TAP      2:0
`define IMU_IOL_LVL       11:8
`define IMU_IOL_DIR       3:0
`define IMU_WR_BIT        15

`define IMU_RNG_300       3'h4
`define IMU_RNG_150       3'h2
`define IMU_RNG_75        3'h1
`define IMU_TAP_MIN150    3'h2
`define IMU_TAP_MIN75     3'h4
`define IMU_TAP_MAX       3'h6
`define IMU_LOWPWR_MIN    8'h0A
`define IMU_EXT_CLK       8'h00

`define IMU_CLK_MHZ       125
`define IMU_TB0_MS        0.61035
`define IMU_TB1_MS        18.921
`define IMU_DRDY_MIN_US   100
`define IMU_DRDY_MAX_US   200
`define IMU_NV_MS         50
`define IMU_SLEEP_LSB_MS  500
`define IMU_STARTUP_CYC   64

`endif

// *** core/imu_pkg.sv ***
// types shared by the imu control logic
`default_nettype none

package imu_pkg;
  typedef enum logic [1:0] {PWR_AWAKE, PWR_TIMED, PWR_INDEF} imu_pwr_t;
  typedef enum logic {RUN_ACTIVE, RUN_STARTUP} imu_run_t;
  typedef struct packed {
    logic       comp_en;
    logic       pop_en;
    logic       stim_neg;
    logic       stim_pos;
    logic [2:0] gyro_range;
    logic [2:0] taps_m;
    logic       low_power;
    logic       ext_clk_mode;
  } imu_cfg_t;
endpackage : imu_pkg

`default_nettype wire

// *** dv/imu_host_model.sv ***
// serial host model: mode 3 master, one word per frame
`default_nettype none
module imu_host_model (
  input  wire logic clk_sys,
  input  wire logic spi_miso,
  output var logic  spi_sclk,
  output var logic  spi_cs_n,
  output var logic  spi_mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spi_sclk = 1'h1;
    spi_cs_n = 1'h1;
    spi_mosi = 1'h0;
  end
  // called just after a rising edge; clock idles high between frames
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    spi_cs_n <= 1'h0;
    repeat (4) @(posedge clk_sys);
    for (int i = 15; i >= 0; i--) begin
      spi_sclk <= 1'h0;
      spi_mosi <= w[i];
      repeat (4) @(posedge clk_sys);
      r[i] = spi_miso;
      spi_sclk <= 1'h1;
      repeat (4) @(posedge clk_sys);
    end
    repeat (8) @(posedge clk_sys);
    spi_cs_n <= 1'h1;
    spi_mosi <= ~spi_mosi;
    repeat (8) @(posedge clk_sys);
  endtask : xfer
endmodule : imu_host_model
`default_nettype wire

// *** dv/imu_ctrl_tb.sv ***
// self-checking bench of the imu control register bank
`default_nettype none
module imu_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, miso_oe_n;
  logic [3:0] dio_in, dio_out, dio_oe_n, alarm_own, alarm_lvl;
  logic [7:0] op_done, op_start;
  logic [1:0] test_done, test_start;
  logic ext_clk;
  int n_tick = 0, n_test = 0, e_test = 0;
  logic burst_start, sample_tick, startup_busy, sleeping;
  imu_pkg::imu_cfg_t cfg;
  logic [15:0] rd, v;
  logic [31:0] seed = 32'h46;
  int n_mismatch = 0, samples_checked = 0, n_ops = 0, n_burst = 0, g;
  imu_ctrl #(.TB0_CYC(8), .TB1_CYC(16), .DRDY_CYC(5), .NV_CYC(20),
    .HALF_S_CYC(10)) uut (.clk_sys, .rst, .spi_sclk, .spi_cs_n,
    .spi_mosi, .spi_miso, .spi_miso_oe_n(miso_oe_n),
    .ext_sample_clk(ext_clk), .dio_in, .dio_out, .dio_oe_n, .alarm_own,
    .alarm_lvl, .op_done, .test_done, .op_start, .test_start,
    .burst_start, .sample_tick, .startup_busy, .sleeping, .cfg);
  imu_host_model host (.clk_sys, .spi_miso, .spi_sclk, .spi_cs_n,
    .spi_mosi);
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    n_ops <= n_ops + op_start[2];
    n_burst <= n_burst + burst_start;
    n_tick <= n_tick + sample_tick;
    n_test <= n_test + test_start[0] + test_start[1];
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [15:0] sens_exp(input logic [2:0] r, t);
    if (t > 3'h6) t = 3'h6;
    if (r == 3'h2 && t < 3'h2) t = 3'h2;
    if (r == 3'h1 && t < 3'h4) t = 3'h4;
    return {5'h00, r, 5'h00, t};
  endfunction : sens_exp
  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string nm, input logic [15:0] e, s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'h1, a, d}, rd);
  endtask : wr
  task automatic rr(input logic [6:0] a);
    host.xfer({1'h0, a, 8'h00}, rd);
    host.xfer(16'h0000, rd);
  endtask : rr
  task automatic tick_gap();
    g = 0;
    do begin
      @(negedge clk_sys);
      g++;
    end while (sample_tick !== 1'h1 && g < 600);
    if (g >= 600) begin
      n_mismatch++;
    end
  endtask : tick_gap
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'h1; dio_in = 4'h0; alarm_own = 4'h0; alarm_lvl = 4'h0;
    op_done = 8'h00; test_done = 2'h0; ext_clk = 1'h0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (4) @(posedge clk_sys);
    check("idle", 16'h001E, {11'h000, miso_oe_n, dio_oe_n});
    rr(7'h36); check("smpl", 16'h0001, rd);
    rr(7'h38); check("sens", 16'h0400, rd);
    rr(7'h30); check("unmapped", 16'h0000, rd);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      e_test += seed[11] + seed[10];
      wr(7'h34, seed[7:0]);
      wr(7'h35, seed[15:8]);
      check("cfg", {12'h000, seed[7:6], seed[9:8]}, {12'h000, cfg.comp_en,
        cfg.pop_en, cfg.stim_neg, cfg.stim_pos});
      @(posedge clk_sys) test_done <= 2'h3;
      @(posedge clk_sys) test_done <= 2'h0;
      rr(7'h34); check("misc", seed[15:0] & 16'h03C7, rd);
    end
    check("tests", 16'(e_test), 16'(n_test));
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wr(7'h39, {5'h00, 3'h1 << (i % 3)});
      wr(7'h38, {5'h00, seed[2:0]});
      rr(7'h38); check("sens", sens_exp(3'h1 << (i % 3), seed[2:0]), rd);
    end
    foreach (v[i]) if (i < 3) begin
      wr(7'h36, (i == 0) ? 8'h09 : (i == 1) ? 8'h0A : 8'h00);
      check("lowpwr", {15'h0000, i == 1}, {15'h0000, cfg.low_power});
      check("extclk", {15'h0000, i == 2}, {15'h0000, cfg.ext_clk_mode});
    end
    wr(7'h36, 8'h00);
    g = n_tick;
    repeat (3) begin
      @(posedge clk_sys) ext_clk <= ~ext_clk;
      repeat (6) @(posedge clk_sys);
    end
    check("exttick", 16'h0002, 16'(n_tick - g));
    for (int i = 0; i < 2; i++) begin
      wr(7'h36, i ? 8'h81 : 8'h01);
      tick_gap();
      tick_gap();
      check("period", i ? 16'h0020 : 16'h0010, 16'(g));
      @(posedge clk_sys);
    end
    wr(7'h34, 8'h06);
    wr(7'h35, 8'h00);
    wr(7'h3E, 8'h05);
    rr(7'h3E); check("cmd", 16'h0005, rd);
    @(posedge clk_sys) op_done <= 8'h05;
    @(posedge clk_sys) op_done <= 8'h00;
    rr(7'h3E); check("cmd", 16'h0000, rd);
    check("ops", 16'h0001, 16'(n_ops));
    check("bursts", 16'h0002, 16'(n_burst));
    wr(7'h3E, 8'h02);
    rr(7'h3E); check("restore", 16'h0000, rd);
    wr(7'h32, 8'h0C);
    wr(7'h33, 8'h08);
    dio_in <= 4'hA;
    check("dio", 16'h0008, {12'h000, dio_out[3:2], dio_oe_n[3:2]});
    rr(7'h32); check("io", 16'h0A0C, rd);
    alarm_own <= 4'hC;
    alarm_lvl <= 4'h4;
    repeat (3) @(posedge clk_sys);
    check("alarm", 16'h0001, {14'h0000, dio_out[3:2]});
    wr(7'h3B, 8'h01); check("sleep", 16'h0001, {15'h0000, sleeping});
    rr(7'h36); check("wake", 16'h0000, {15'h0000, sleeping});
    wr(7'h3A, 8'h02); check("tsleep", 16'h0001, {15'h0000, sleeping});
    repeat (20) @(posedge clk_sys);
    check("tsleep", 16'h0000, {15'h0000, sleeping});
    wr(7'h34, 8'h86);
    wr(7'h3E, 8'h80); check("busy", 16'h0001, {15'h0000, startup_busy});
    for (g = 0; startup_busy !== 1'h0 && g < 200; g++) @(posedge clk_sys);
    if (g >= 200) begin
      n_mismatch++;
    end
    rr(7'h34); check("misc", 16'h0006, rd);
    report_and_stop();
  end
endmodule : imu_ctrl_tb
`default_nettype wire
